/* rtl/lpc_pkg.sv */
// Constants and types shared by the ladder checksum unit
package lpc_pkg;
    // ==========================================================
    // Checksum arithmetic
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_SEED = 8'h00;
    localparam int CRC_STEPS = 8;

    // ==========================================================
    // Register map and field positions
    localparam logic [7:0] CFG_OFFSET = 8'h08;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam int CFG_PEC_ALARM_BIT = 6;
    localparam int DCB_ALARM_BIT = 7;
    localparam int DCB_ERR_BIT = 0;

    // ==========================================================
    // Write frame layout on the lower port
    localparam logic [7:0] BCAST_WR_ADDR = 8'h40;
    localparam logic [2:0] WR_IDX_ADDR = 3'h0;
    localparam logic [2:0] WR_IDX_REG = 3'h1;
    localparam logic [2:0] WR_IDX_DLO = 3'h2;
    localparam logic [2:0] WR_IDX_DHI = 3'h3;
    localparam logic [2:0] WR_IDX_PEC = 3'h4;
    localparam logic [2:0] WR_IDX_MAX = 3'h5;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        LPC_UP_DATA,
        LPC_UP_DCB,
        LPC_UP_PEC
    } lpc_kind_e;

    typedef enum logic [1:0] {
        LPC_TX_IDLE,
        LPC_TX_DCB,
        LPC_TX_GAP,
        LPC_TX_PEC
    } lpc_tx_e;
endpackage

/* rtl/lpc_crc_if.sv */
// Byte feed and running checksum between the unit and a checksum lane
`timescale 1ns/1ps
`default_nettype none
interface lpc_crc_if;
    logic clr;
    logic valid;
    logic [7:0] data;
    logic [7:0] crc;

    modport lane (input clr, input valid, input data, output crc);
    modport user (output clr, output valid, output data, input crc);
endinterface
`default_nettype wire

/* rtl/lpc_crc8_step.sv */
// One whole byte of checksum update, eight shift steps unrolled by a loop
`timescale 1ns/1ps
`default_nettype none
module lpc_crc8_step (
    input wire logic [7:0] crc_in,
    input wire logic [7:0] data_in,
    output logic [7:0] crc_out
);
    import lpc_pkg::*;

    logic [7:0] rem;

    always_comb begin
        rem = crc_in ^ data_in;
        // Top bit drops out of the shift; it would cancel against x^8
        for (int i = 0; i < CRC_STEPS; i++) begin
            if (rem[7]) begin
                rem = {rem[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                rem = {rem[6:0], 1'b0};
            end
        end
        crc_out = rem;
    end
endmodule
`default_nettype wire

/* rtl/lpc_crc_lane.sv */
// Running checksum register fed one byte per valid cycle
`timescale 1ns/1ps
`default_nettype none
module lpc_crc_lane (
    input wire logic clk,
    input wire logic rst_n,
    lpc_crc_if.lane bus
);
    import lpc_pkg::*;

    logic [7:0] crc_r;
    logic [7:0] crc_nxt;

    lpc_crc8_step u_step (
        .crc_in(crc_r),
        .data_in(bus.data),
        .crc_out(crc_nxt)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_r <= CRC_SEED;
        end else if (bus.clr) begin
            crc_r <= CRC_SEED;
        end else if (bus.valid) begin
            crc_r <= crc_nxt;
        end
    end

    assign bus.crc = crc_r;
endmodule
`default_nettype wire

/* rtl/lpc_pec_unit.sv */
// Packet checksum unit: write check on the lower port, read relay from the upper port
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Bad-checksum writes leave registers untouched
// - Write acknowledge reports own checksum result only
// - Checksum alert drives alarm only when enabled
// - Checksum is CRC-8, feedback constant 07
// - Cover address, command, data, check bytes
// - Bits enter most significant first
// - Running checksum clears at message start
// - Remainder is byte XOR running checksum
// - Shift left; XOR constant if top set
// - Eight steps per byte, result carried on
// - Final running value is the checksum byte
// - Held in reset: no response, no forwarding
// - Check byte: alarm bit 7, error bit 0
// - Bad upper checksum sets alert and error flag
module lpc_pec_unit (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic lo_start,
    input wire logic lo_stop,
    input wire logic lo_valid,
    input wire logic [7:0] lo_byte,
    output logic lo_ack_valid,
    output logic lo_ack,
    input wire logic up_start,
    input wire logic up_valid,
    input wire lpc_pkg::lpc_kind_e up_kind,
    input wire logic [7:0] up_byte,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic alarm_cond,
    input wire logic alert_clr,
    output logic [15:0] converter_config,
    output logic reg_wr,
    output logic [7:0] reg_wr_addr,
    output logic [15:0] reg_wr_data,
    output logic checksum_error_alert,
    output logic alarm_out,
    output logic pec_err
);
    import lpc_pkg::*;

    // ==========================================================
    // Reset release
    // Power-on reset holds everything; bus bytes are dropped meanwhile
    logic rst_s1_r;
    logic rst_s2_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // ==========================================================
    // Checksum lanes
    lpc_crc_if lo_if ();
    lpc_crc_if up_if ();
    lpc_crc_if tx_if ();

    lpc_crc_lane u_lo_lane (
        .clk(mclk),
        .rst_n(rst_s2_r),
        .bus(lo_if)
    );

    lpc_crc_lane u_up_lane (
        .clk(mclk),
        .rst_n(rst_s2_r),
        .bus(up_if)
    );

    lpc_crc_lane u_tx_lane (
        .clk(mclk),
        .rst_n(rst_s2_r),
        .bus(tx_if)
    );

    logic lo_open_r;
    logic [2:0] lo_idx_r;
    logic lo_is_wr_r;
    logic [7:0] lo_reg_r;
    logic [7:0] lo_dlo_r;
    logic [7:0] lo_dhi_r;
    logic up_open_r;
    logic [7:0] dcb_r;
    lpc_tx_e tx_st_r;
    logic tx_valid_r;
    logic tx_is_pec_r;
    logic [7:0] tx_byte_r;
    logic [15:0] cfg_r;
    logic alert_r;

    logic lo_take;
    logic lo_pec_take;
    logic lo_pec_ok;
    logic up_take;
    logic up_pec_take;
    logic up_pec_bad;

    // Bytes outside an open frame are never counted
    assign lo_take = lo_valid & lo_open_r & ~lo_start;
    assign lo_pec_take = lo_take & lo_is_wr_r & (lo_idx_r == WR_IDX_PEC);
    assign lo_pec_ok = (lo_byte == lo_if.crc);
    assign up_take = up_valid & up_open_r & ~up_start;
    assign up_pec_take = up_take & (up_kind == LPC_UP_PEC);
    assign up_pec_bad = up_pec_take & (up_byte != up_if.crc);

    // Checksum byte itself never enters its own lane
    assign lo_if.clr = lo_start;
    assign lo_if.valid = lo_take & ~lo_pec_take;
    assign lo_if.data = lo_byte;

    assign up_if.clr = up_start;
    assign up_if.valid = up_take & (up_kind != LPC_UP_PEC);
    assign up_if.data = up_byte;

    // Outgoing lane covers the read command then every byte sent down except the checksum byte.
    // Sent bytes win; the host does not talk while the ladder answers.
    assign tx_if.clr = lo_start;
    assign tx_if.valid = (tx_valid_r & ~tx_is_pec_r) | lo_take;
    assign tx_if.data = (tx_valid_r & ~tx_is_pec_r) ? tx_byte_r : lo_byte;

    // ==========================================================
    // Lower port frame tracking
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            lo_open_r <= 1'b0;
            lo_idx_r <= WR_IDX_ADDR;
            lo_is_wr_r <= 1'b0;
        end else if (lo_start) begin
            lo_open_r <= 1'b1;
            lo_idx_r <= WR_IDX_ADDR;
            lo_is_wr_r <= 1'b0;
        end else if (lo_stop) begin
            // A write cut short before its checksum is simply dropped
            lo_open_r <= 1'b0;
        end else if (lo_take) begin
            if (lo_idx_r == WR_IDX_ADDR) begin
                lo_is_wr_r <= (lo_byte == BCAST_WR_ADDR);
            end
            if (lo_idx_r != WR_IDX_MAX) begin
                lo_idx_r <= lo_idx_r + 3'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            lo_reg_r <= 8'h00;
            lo_dlo_r <= 8'h00;
            lo_dhi_r <= 8'h00;
        end else if (lo_take) begin
            case (lo_idx_r)
                WR_IDX_REG: begin
                    lo_reg_r <= lo_byte;
                end
                WR_IDX_DLO: begin
                    lo_dlo_r <= lo_byte;
                end
                WR_IDX_DHI: begin
                    lo_dhi_r <= lo_byte;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Write execution and acknowledge
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            lo_ack_valid <= 1'b0;
            lo_ack <= 1'b0;
        end else begin
            lo_ack_valid <= lo_pec_take;
            lo_ack <= lo_pec_take & lo_pec_ok;
        end
    end

    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            cfg_r <= CFG_RESET;
        end else if (lo_pec_take && lo_pec_ok && lo_reg_r == CFG_OFFSET) begin
            cfg_r <= {lo_dhi_r, lo_dlo_r};
        end
    end

    // Other register offsets are handed out only after a good checksum
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            reg_wr <= 1'b0;
            reg_wr_addr <= 8'h00;
            reg_wr_data <= 16'h0000;
        end else begin
            reg_wr <= lo_pec_take & lo_pec_ok & (lo_reg_r != CFG_OFFSET);
            if (lo_pec_take && lo_pec_ok) begin
                reg_wr_addr <= lo_reg_r;
                reg_wr_data <= {lo_dhi_r, lo_dlo_r};
            end
        end
    end

    // ==========================================================
    // Upper port frame and check byte capture
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            up_open_r <= 1'b0;
        end else if (up_start) begin
            up_open_r <= 1'b1;
        end else if (up_pec_take) begin
            up_open_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            dcb_r <= 8'h00;
        end else if (up_take && up_kind == LPC_UP_DCB) begin
            dcb_r <= up_byte;
        end
    end

    // ==========================================================
    // Downward relay: data passes on, check byte waits for the checksum
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            tx_st_r <= LPC_TX_IDLE;
            tx_valid_r <= 1'b0;
            tx_is_pec_r <= 1'b0;
            tx_byte_r <= 8'h00;
        end else begin
            tx_valid_r <= 1'b0;
            tx_is_pec_r <= 1'b0;
            case (tx_st_r)
                LPC_TX_IDLE: begin
                    if (up_take && up_kind == LPC_UP_DATA) begin
                        tx_valid_r <= 1'b1;
                        tx_byte_r <= up_byte;
                    end
                    if (up_pec_take) begin
                        tx_st_r <= LPC_TX_DCB;
                    end
                end
                LPC_TX_DCB: begin
                    // Alert already holds any upper mismatch at this point
                    tx_valid_r <= 1'b1;
                    tx_byte_r <= 8'h00;
                    tx_byte_r[DCB_ALARM_BIT] <= dcb_r[DCB_ALARM_BIT] | alarm_cond
                        | alarm_out;
                    tx_byte_r[DCB_ERR_BIT] <= dcb_r[DCB_ERR_BIT] | alert_r;
                    tx_st_r <= LPC_TX_GAP;
                end
                LPC_TX_GAP: begin
                    // Lets the lane absorb the check byte before it is read
                    tx_st_r <= LPC_TX_PEC;
                end
                LPC_TX_PEC: begin
                    tx_valid_r <= 1'b1;
                    tx_is_pec_r <= 1'b1;
                    tx_byte_r <= tx_if.crc;
                    tx_st_r <= LPC_TX_IDLE;
                end
                default: begin
                    tx_st_r <= LPC_TX_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Alert, alarm and error strobe
    // Set beats clear so a mismatch in the clearing cycle survives
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            alert_r <= 1'b0;
        end else if (up_pec_bad || (lo_pec_take && !lo_pec_ok)) begin
            alert_r <= 1'b1;
        end else if (alert_clr) begin
            alert_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            alarm_out <= 1'b0;
        end else begin
            alarm_out <= alert_r & cfg_r[CFG_PEC_ALARM_BIT];
        end
    end

    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            pec_err <= 1'b0;
        end else begin
            pec_err <= up_pec_bad | (lo_pec_take & ~lo_pec_ok);
        end
    end

    assign tx_valid = tx_valid_r;
    assign tx_byte = tx_byte_r;
    assign converter_config = cfg_r;
    assign checksum_error_alert = alert_r;
endmodule
`default_nettype wire

/* bench/lpc_pec_unit_props.sv */
// Port assertions for the ladder checksum unit
`timescale 1ns/1ps
`default_nettype none
module lpc_pec_unit_props (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic lo_valid,
    input wire logic up_valid,
    input wire lpc_pkg::lpc_kind_e up_kind,
    input wire logic [7:0] up_byte,
    input wire logic lo_ack_valid,
    input wire logic lo_ack,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic [15:0] converter_config,
    input wire logic reg_wr,
    input wire logic checksum_error_alert,
    input wire logic alarm_out,
    input wire logic pec_err
);
    import lpc_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Lower port writes
    property p_ack_cause;
        lo_ack_valid |-> $past(lo_valid);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack with no byte");
    property p_cfg_guard;
        !$stable(converter_config) |-> lo_ack_valid && lo_ack;
    endproperty
    a_cfg_guard: assert property (p_cfg_guard) else $error("config changed");
    property p_wr_ok;
        reg_wr |-> lo_ack_valid && lo_ack;
    endproperty
    a_wr_ok: assert property (p_wr_ok) else $error("write without ack");
    property p_nak_err;
        lo_ack_valid && !lo_ack |-> pec_err && checksum_error_alert;
    endproperty
    a_nak_err: assert property (p_nak_err) else $error("nak without error");
    property p_err_pulse;
        pec_err |=> !pec_err;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("error strobe long");
    property p_alert_set;
        pec_err |-> checksum_error_alert;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("alert not set");
    property p_alarm_gate;
        !converter_config[CFG_PEC_ALARM_BIT] && !$past(converter_config[CFG_PEC_ALARM_BIT])
            |-> !alarm_out;
    endproperty
    a_alarm_gate: assert property (p_alarm_gate) else $error("alarm not gated");
    // ==========================================================
    // Upper relay
    property p_fwd;
        up_valid && up_kind == LPC_UP_DATA |=> tx_valid && tx_byte == $past(up_byte);
    endproperty
    a_fwd: assert property (p_fwd) else $error("data not forwarded");
    property p_dcb;
        up_valid && up_kind == LPC_UP_PEC |-> ##2 tx_valid && tx_byte[6:1] == 6'h00 ##2 tx_valid;
    endproperty
    a_dcb: assert property (p_dcb) else $error("check byte or checksum");
    c_ack: cover property (lo_ack_valid && lo_ack);
    c_nak: cover property (lo_ack_valid && !lo_ack);
    c_alarm: cover property (alarm_out);
endmodule
`default_nettype wire

/* bench/lpc_ladder_model.sv */
// Host and upper neighbour driving both ports of the checksum unit
`timescale 1ns/1ps
`default_nettype none
module lpc_ladder_model (
    input wire logic mclk,
    output logic lo_start,
    output logic lo_stop,
    output logic lo_valid,
    output logic [7:0] lo_byte,
    output logic up_start,
    output logic up_valid,
    output var lpc_pkg::lpc_kind_e up_kind,
    output logic [7:0] up_byte
);
    import lpc_pkg::*;
    initial begin
        {lo_start, lo_stop, lo_valid, up_start, up_valid} = 5'h00;
        lo_byte = 8'h00;
        up_byte = 8'h00;
        up_kind = LPC_UP_DATA;
    end
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? {r[6:0], 1'b0} ^ CRC_POLY : {r[6:0], 1'b0};
        end
        return r;
    endfunction
    function automatic logic [7:0] crcq(input logic [7:0] q[$]);
        logic [7:0] c;
        c = 8'h00;
        foreach (q[i]) c = crc8(c, q[i]);
        return c;
    endfunction
    task automatic lo_frame(input logic [7:0] q[$], input logic stop);
        @(posedge mclk);
        lo_start <= 1'b1;
        foreach (q[i]) begin
            @(posedge mclk);
            lo_start <= 1'b0;
            lo_valid <= 1'b1;
            lo_byte <= q[i];
        end
        @(posedge mclk);
        lo_start <= 1'b0;
        lo_valid <= 1'b0;
        lo_byte <= ~lo_byte;  // Released line shows no stale byte
        lo_stop <= stop;
        @(posedge mclk);
        lo_stop <= 1'b0;
    endtask
    task automatic write(input logic [7:0] off, input logic [15:0] v, input logic [7:0] flip);
        logic [7:0] q[$];
        q = {BCAST_WR_ADDR, off, v[7:0], v[15:8]};
        q.push_back(crcq(q) ^ flip);
        lo_frame(q, 1'b1);
    endtask
    task automatic up_frame(input logic [7:0] q[$], input logic [7:0] dcb,
        input logic [7:0] flip);
        logic [7:0] c;
        c = 8'h00;
        @(posedge mclk);
        up_start <= 1'b1;
        foreach (q[i]) begin
            @(posedge mclk);
            up_start <= 1'b0;
            up_valid <= 1'b1;
            up_kind <= LPC_UP_DATA;
            up_byte <= q[i];
            c = crc8(c, q[i]);
        end
        @(posedge mclk);
        up_kind <= LPC_UP_DCB;
        up_byte <= dcb;
        @(posedge mclk);
        up_kind <= LPC_UP_PEC;
        up_byte <= crc8(c, dcb) ^ flip;
        @(posedge mclk);
        up_valid <= 1'b0;
        up_byte <= ~up_byte;
        repeat (5) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

/* bench/lpc_pec_unit_bench.sv */
// Self-checking bench for the ladder checksum unit
`timescale 1ns/1ps
`default_nettype none
module lpc_pec_unit_bench;
    import lpc_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic alarm_cond = 1'b0;
    logic alert_clr = 1'b0;
    logic lo_start, lo_stop, lo_valid, up_start, up_valid, b;
    logic [7:0] lo_byte, up_byte, tx_byte, reg_wr_addr, dcb;
    lpc_kind_e up_kind;
    logic lo_ack_valid, lo_ack, tx_valid, reg_wr, checksum_error_alert, alarm_out, pec_err;
    logic [15:0] converter_config, reg_wr_data;
    logic acked, ack_seen;
    logic [23:0] wr_info;
    logic [7:0] q[$];
    logic [7:0] d[$];
    logic [7:0] txq[$];
    int failures = 0;
    int samples_checked = 0;
    int errs = 0;
    always #10 mclk = ~mclk;
    lpc_pec_unit u_dut (
        .mclk, .rst_n, .lo_start, .lo_stop, .lo_valid, .lo_byte, .lo_ack_valid, .lo_ack,
        .up_start, .up_valid, .up_kind, .up_byte, .tx_valid, .tx_byte, .alarm_cond,
        .alert_clr, .converter_config, .reg_wr, .reg_wr_addr, .reg_wr_data,
        .checksum_error_alert, .alarm_out, .pec_err
    );
    lpc_ladder_model u_mdl (
        .mclk, .lo_start, .lo_stop, .lo_valid, .lo_byte, .up_start, .up_valid, .up_kind,
        .up_byte
    );
    // One-cycle outputs are latched here for later comparison
    always @(posedge mclk) begin
        if (tx_valid) txq.push_back(tx_byte);
        if (pec_err) errs++;
        if (lo_ack_valid) {acked, ack_seen} = {1'b1, lo_ack};
        if (reg_wr) wr_info = {reg_wr_addr, reg_wr_data};
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic clr(input string done);
        @(negedge mclk);
        $display("test %s done", done);
        txq.delete();
        {acked, ack_seen, wr_info} = 26'h0;
        errs = 0;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #50us;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge mclk);
        chk("reset", 0, {converter_config, tx_valid, lo_ack_valid, pec_err, alarm_out});
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        clr("reset");
        q = {8'h40, 8'h09, 8'hFF, 8'h03};
        chk("example sum", 32'h7F, u_mdl.crcq(q));
        d = {8'h40, 8'h09};
        chk("seeded sum", 32'h7F, u_mdl.crc8(u_mdl.crc8(u_mdl.crcq(d), 8'hFF), 8'h03));
        u_mdl.write(8'h09, 16'h03FF, 8'h00);
        repeat (2) @(posedge mclk);
        chk("write", {2'h3, 24'h0903FF}, {acked, ack_seen, wr_info});
        u_mdl.write(CFG_OFFSET, 16'h0040, 8'h00);
        u_mdl.write(CFG_OFFSET, 16'hFFFF, 8'h01);
        repeat (3) @(posedge mclk);
        chk("bad write", {16'h0040, 4'hB, 2'h1}, {converter_config, acked, ack_seen,
            checksum_error_alert, alarm_out, errs[1:0]});
        clr("write");
        q = {8'h40, 8'h08, 8'h00};
        u_mdl.lo_frame(q, 1'b1);
        alert_clr <= 1'b1;
        @(posedge mclk);
        alert_clr <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("short frame", 32'h0040,
            {acked, checksum_error_alert, alarm_out, converter_config});
        u_mdl.write(CFG_OFFSET, 16'h0000, 8'h00);
        for (int i = 0; i < 2; i++) begin
            clr("frames");
            b = i[0];
            q = {8'h41, 8'h02, 8'h41};
            u_mdl.lo_frame(q, 1'b0);
            // Driven on the rising edge the frame task returns on
            alarm_cond <= b;
            d = {8'hAA, 8'h5B};
            u_mdl.up_frame(d, {7'h00, b}, {7'h00, b});
            dcb = {b, 6'h00, b};
            q = {q, d, dcb};
            chk("relay", {8'hAA, 8'h5B, dcb, u_mdl.crcq(q)},
                {txq[0], txq[1], txq[2], txq[3]});
            chk("relay flags", {b, 1'b0, 1'b0, b},
                {checksum_error_alert, alarm_out, errs[1:0]});
        end
        clr("relay");
        print_verdict();
    end
endmodule
bind lpc_pec_unit lpc_pec_unit_props u_props (
    .mclk, .rst_n, .lo_valid, .up_valid, .up_kind, .up_byte, .lo_ack_valid, .lo_ack,
    .tx_valid, .tx_byte, .converter_config, .reg_wr, .checksum_error_alert, .alarm_out,
    .pec_err
);
`default_nettype wire
